// File: src/gso_pkg.sv
// Constants and types for the gauge shutdown timer and result register bank.
package gso_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] GSO_ADDR_REP_CAP      = 8'h05;
  localparam logic [7:0] GSO_ADDR_REP_PCT      = 8'h06;
  localparam logic [7:0] GSO_ADDR_AGE          = 8'h07;
  localparam logic [7:0] GSO_ADDR_UNAVAIL_CAP  = 8'h0c;
  localparam logic [7:0] GSO_ADDR_BLEND_PCT    = 8'h0d;
  localparam logic [7:0] GSO_ADDR_AVAIL_PCT    = 8'h0e;
  localparam logic [7:0] GSO_ADDR_BLEND_CAP    = 8'h0f;
  localparam logic [7:0] GSO_ADDR_FULL_CAP     = 8'h10;
  localparam logic [7:0] GSO_ADDR_SHDN_CTRL    = 8'h3f;
  localparam logic [7:0] GSO_ADDR_LAST_SAMPLE  = 8'h4c;
  localparam logic [7:0] GSO_ADDR_RIPPLE       = 8'hbc;
  localparam logic [7:0] GSO_ADDR_TICK_HIGH    = 8'hbe;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          GSO_DSEL_MSB         = 15;
  localparam int          GSO_DSEL_LSB         = 13;
  localparam int          GSO_ELAPSED_MSB      = 12;
  localparam logic [2:0]  GSO_DSEL_RST         = 3'h7;
  localparam logic [15:0] GSO_WORD_RST         = 16'h0000;
  localparam logic [12:0] GSO_ELAPSED_RST      = 13'h0000;

  // ----------------------------------------------------------------------
  // Timing: one task tick is 175.8 ms; one elapsed count is eight ticks.
  // ----------------------------------------------------------------------
  localparam int          GSO_TASK_INTERVAL_US = 175800;
  localparam logic [2:0]  GSO_TICKS_PER_COUNT_LAST = 3'h7;
  // Timeout is 2^(8+sel) ticks, i.e. 2^(5+sel) elapsed counts.
  localparam int          GSO_COUNT_BASE_EXP   = 5;

  // ----------------------------------------------------------------------
  // Arithmetic scales for full capacity and age
  // ----------------------------------------------------------------------
  localparam int          GSO_FACTOR_SHIFT     = 15;
  localparam logic [31:0] GSO_AGE_SCALE        = 32'h0000_6400;

  // Result words loaded whole by the gauge engine.
  typedef enum logic [2:0] {
    GSO_RES_REP_CAP     = 3'h0,
    GSO_RES_REP_PCT     = 3'h1,
    GSO_RES_UNAVAIL_CAP = 3'h2,
    GSO_RES_BLEND_PCT   = 3'h3,
    GSO_RES_AVAIL_PCT   = 3'h4,
    GSO_RES_RIPPLE      = 3'h5
  } gso_res_t;
  localparam int          GSO_NRES             = 6;

  // Shutdown sequence states.
  typedef enum logic [2:0] {
    GSO_ST_IDLE  = 3'b001,
    GSO_ST_COUNT = 3'b010,
    GSO_ST_OFF   = 3'b100
  } gso_state_t;

endpackage

// File: src/gso_shdn_timer.sv
// Shutdown delay sequencer with elapsed-time counter.
`timescale 1ns/1ns
module gso_shdn_timer
  import gso_pkg::*;
(
  input  wire logic        clk,            // System clock.
  input  wire logic        rst_b,          // Synchronous reset, active low.
  input  wire logic        task_tick,      // One pulse per task interval.
  input  wire logic        shdn_event,     // Synchronised shutdown request level.
  input  wire logic [2:0]  delay_sel,      // Shutdown delay select.
  output logic      [12:0] elapsed_count,  // Elapsed time in 1.4 s counts.
  output logic             regulator_off,  // Regulator output disabled.
  output logic             low_power       // Low-power mode entered.
);

  gso_state_t  state;
  gso_state_t  next_state;
  logic [2:0]  tick_div;
  logic [12:0] limit;
  wire         count_step = task_tick && (tick_div == GSO_TICKS_PER_COUNT_LAST);
  wire         done       = count_step && ((elapsed_count + 13'h0001) == limit);

  // Timeout in elapsed counts; the widest case, 4096, still fits 13 bits.
  assign limit = 13'h0001 << (GSO_COUNT_BASE_EXP + int'(delay_sel));

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // A request that drops before the timeout cancels the sequence.
  always_comb begin
    case (state)
      GSO_ST_IDLE:  next_state = shdn_event ? GSO_ST_COUNT : GSO_ST_IDLE;
      GSO_ST_COUNT: next_state = !shdn_event ? GSO_ST_IDLE :
                                 (done ? GSO_ST_OFF : GSO_ST_COUNT);
      GSO_ST_OFF:   next_state = GSO_ST_OFF;
      default:      next_state = GSO_ST_IDLE;
    endcase
  end

  // Counter runs only while counting and clears when the timeout ends.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state         <= GSO_ST_IDLE;
      tick_div      <= 3'h0;
      elapsed_count <= GSO_ELAPSED_RST;
    end else begin
      state <= next_state;
      if (state != GSO_ST_COUNT || !shdn_event || done) begin
        tick_div      <= 3'h0;
        elapsed_count <= GSO_ELAPSED_RST;
      end else if (task_tick) begin
        tick_div <= tick_div + 3'h1;
        if (count_step) elapsed_count <= elapsed_count + 13'h0001;
      end
    end
  end

  assign regulator_off = (state == GSO_ST_OFF);
  assign low_power     = (state == GSO_ST_OFF);

  // Timeout expiry ends counting and shuts the output down next cycle.
  sequence timeout_seq;
    state == GSO_ST_COUNT && shdn_event && done;
  endsequence
  timeout_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    timeout_seq |=> regulator_off && low_power && elapsed_count == 13'h0000)
    else $error("Shutdown did not take effect at timeout.");
  counter_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    elapsed_count < limit || state != GSO_ST_COUNT)
    else $error("Elapsed count passed the programmed timeout.");

endmodule

// File: src/gso_full_capacity_comp_calc.sv
// Temperature-corrected full capacity and age ratio.
`timescale 1ns/1ns
module gso_full_capacity_comp_calc
  import gso_pkg::*;
(
  input  wire logic        clk,             // System clock.
  input  wire logic        rst_b,           // Synchronous reset, active low.
  input  wire logic [15:0] full_capacity_nominal, // Nominal full capacity.
  input  wire logic [15:0] full_cap_temp_factor,  // Temperature factor, 1.0 = 0x8000.
  input  wire logic [15:0] design_capacity, // Design capacity.
  output logic      [15:0] full_capacity_comp,    // Corrected full capacity.
  output logic      [15:0] age_ratio        // Full over design, percent 8.8.
);

  wire [31:0] product  = full_capacity_nominal * full_cap_temp_factor;
  wire [31:0] scaled   = product >> GSO_FACTOR_SHIFT;
  wire [15:0] next_full = (scaled[31:16] != 16'h0000) ? 16'hffff : scaled[15:0];
  wire [31:0] age_num  = full_capacity_comp * GSO_AGE_SCALE;
  wire [31:0] age_quot = (design_capacity == 16'h0000) ? 32'h0000_0000 :
                         age_num / {16'h0000, design_capacity};
  wire [15:0] next_age = (age_quot[31:16] != 16'h0000) ? 16'hffff : age_quot[15:0];

  // Both results land as whole words; the age lags the capacity one cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      full_capacity_comp <= GSO_WORD_RST;
      age_ratio          <= GSO_WORD_RST;
    end else begin
      full_capacity_comp <= next_full;
      age_ratio          <= next_age;
    end
  end

  age_track_a: assert property (@(posedge clk) disable iff (!rst_b)
    design_capacity == full_capacity_comp && design_capacity != 16'h0000
    && $stable(design_capacity) |=> age_ratio == 16'h6400)
    else $error("Age ratio is not 100 percent at equal capacities.");

endmodule

// File: src/gso_bank.sv
// Gauge shutdown timer, tick counter extension and result register bank.
//
// Notes on behaviour
// - Shutdown timeout is 175.8 ms times two to the (8 plus select).
// - Delay select resets to 7, about 1.6 hours.
// - After timeout following a shutdown event, regulator turns off, low power entered.
// - Thirteen-bit elapsed counter counts 1.4 s steps since the trigger.
// - Elapsed counter stops and returns to zero when timeout completes.
// - Sixteen-bit high word extends the tick counter to thirty-two bits.
// - High word may be saved and restored when selected.
// - Reported capacity holds a smoothed copy of available capacity.
// - Charge percent words: upper byte whole percent, lower byte fraction.
// - Age holds full over design capacity, percent in 8.8 form.
// - Full capacity is nominal capacity times temperature factor.
// - Blended capacity accumulates measured current every task tick.
// - Unavailable capacity reports impedance and load losses.
// - Ripple compensation is a 16-bit internal word.
// - Last charge sample keeps the latest sampled charge value.
// - Low tick counter advances once per task interval.
`timescale 1ns/1ns
module gso_bank
  import gso_pkg::*;
(
  input  wire logic        clk,               // System clock, 20 MHz.
  input  wire logic        rst_b,             // Synchronous reset, active low.
  input  wire logic        task_tick,         // Task interval pulse, same clock.
  input  wire logic        shutdown_pin,      // Shutdown request from a pin.
  input  wire logic [7:0]  reg_addr,          // Register address.
  input  wire logic        reg_wr,            // Write strobe.
  input  wire logic [15:0] reg_wdata,         // Write data.
  input  wire logic        reg_rd,            // Read strobe.
  output logic      [15:0] reg_rdata,         // Read data, registered.
  output logic             reg_rvalid,        // Read data valid pulse.
  input  wire logic        res_wr,            // Result word load strobe.
  input  wire gso_res_t    res_sel,           // Which result word to load.
  input  wire logic [15:0] res_data,          // Result word value.
  input  wire logic [15:0] current_sample,    // Signed current per tick.
  input  wire logic [15:0] charge_sample,     // Latest sampled charge.
  input  wire logic [15:0] full_capacity_nominal, // Nominal full capacity.
  input  wire logic [15:0] full_cap_temp_factor,  // Temperature correction factor.
  input  wire logic [15:0] design_capacity,   // Design capacity.
  input  wire logic        tick_high_save_en, // High word takes part in save.
  input  wire logic        tick_high_restore, // Restore strobe for high word.
  input  wire logic [15:0] tick_high_restore_value, // Value to restore.
  output logic      [15:0] tick_high_save_value,    // Saved copy of high word.
  output logic      [15:0] tick_count_low,    // Low tick counter.
  output logic             regulator_off,     // Regulator output disabled.
  output logic             low_power          // Low-power mode entered.
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Address match, shared by the read mux and the write decode.
  function automatic logic gso_hit(input logic [7:0] a, input logic [7:0] off);
    gso_hit = (a == off);
  endfunction

  logic [2:0]  delay_sel;
  logic [12:0] elapsed_count;
  logic [15:0] tick_count_high;
  logic [15:0] blended_capacity;
  logic [15:0] last_charge_sample;
  logic [15:0] full_capacity_comp;
  logic [15:0] capacity_age_ratio;
  logic [15:0] result_q [GSO_NRES];
  logic        shdn_meta;
  logic        shdn_sync;
  logic [15:0] next_rdata;

  wire wr_shdn     = reg_wr && gso_hit(reg_addr, GSO_ADDR_SHDN_CTRL);
  wire wr_tick_hi  = reg_wr && gso_hit(reg_addr, GSO_ADDR_TICK_HIGH);
  wire low_wrap    = task_tick && (tick_count_low == 16'hffff);

  // ----------------------------------------------------------------------
  // Shutdown pin synchroniser
  // ----------------------------------------------------------------------
  // The pin is asynchronous, so only the second stage is read.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shdn_meta <= 1'b0;
      shdn_sync <= 1'b0;
    end else begin
      shdn_meta <= shutdown_pin;
      shdn_sync <= shdn_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Shutdown delay control
  // ----------------------------------------------------------------------
  // Only the select field is writable; the counter bits are ignored.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      delay_sel <= GSO_DSEL_RST;
    end else if (wr_shdn) begin
      delay_sel <= reg_wdata[GSO_DSEL_MSB:GSO_DSEL_LSB];
    end
  end

  gso_shdn_timer u_shdn_timer (
    .clk           (clk),
    .rst_b         (rst_b),
    .task_tick     (task_tick),
    .shdn_event    (shdn_sync),
    .delay_sel     (delay_sel),
    .elapsed_count (elapsed_count),
    .regulator_off (regulator_off),
    .low_power     (low_power)
  );

  // ----------------------------------------------------------------------
  // Tick counter and its high-word extension
  // ----------------------------------------------------------------------
  // A restore beats a host write, which beats the carry, so a restored
  // value is never bumped in the same cycle it lands.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_count_low  <= GSO_WORD_RST;
      tick_count_high <= GSO_WORD_RST;
    end else begin
      if (task_tick) tick_count_low <= tick_count_low + 16'h0001;
      if (tick_high_restore && tick_high_save_en) begin
        tick_count_high <= tick_high_restore_value;
      end else if (wr_tick_hi) begin
        tick_count_high <= reg_wdata;
      end else if (low_wrap) begin
        tick_count_high <= tick_count_high + 16'h0001;
      end
    end
  end

  // Save copy shows zero unless the high word is enrolled for saving.
  assign tick_high_save_value = tick_high_save_en ? tick_count_high : 16'h0000;

  // ----------------------------------------------------------------------
  // Result words loaded by the gauge engine
  // ----------------------------------------------------------------------
  // Each word is written whole in one edge, so reads see old or new only.
  generate
    for (genvar i = 0; i < GSO_NRES; i++) begin : g_res
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          result_q[i] <= GSO_WORD_RST;
        end else if (res_wr && (res_sel == gso_res_t'(i))) begin
          result_q[i] <= res_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Blended capacity and charge sample
  // ----------------------------------------------------------------------
  // Current is added as a signed step and clamped at both ends, since a
  // wrap would report a full battery as empty.
  wire [16:0] blend_sum = {1'b0, blended_capacity} + {current_sample[15], current_sample};
  wire [15:0] next_blend = current_sample[15] ? (blend_sum[16] ? 16'h0000 : blend_sum[15:0])
                                              : (blend_sum[16] ? 16'hffff : blend_sum[15:0]);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blended_capacity   <= GSO_WORD_RST;
      last_charge_sample <= GSO_WORD_RST;
    end else if (task_tick) begin
      blended_capacity   <= next_blend;
      last_charge_sample <= charge_sample;
    end
  end

  gso_full_capacity_comp_calc u_full_capacity_comp_calc (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .full_capacity_nominal (full_capacity_nominal),
    .full_cap_temp_factor  (full_cap_temp_factor),
    .design_capacity       (design_capacity),
    .full_capacity_comp    (full_capacity_comp),
    .age_ratio             (capacity_age_ratio)
  );

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Capacity words are 0.5 mAh counts; percent words are 8.8 fixed point.
  // Unmapped addresses read as zero.
  always_comb begin
    next_rdata = 16'h0000;
    if (gso_hit(reg_addr, GSO_ADDR_REP_CAP))     next_rdata = result_q[0];
    if (gso_hit(reg_addr, GSO_ADDR_REP_PCT))     next_rdata = result_q[1];
    if (gso_hit(reg_addr, GSO_ADDR_AGE))         next_rdata = capacity_age_ratio;
    if (gso_hit(reg_addr, GSO_ADDR_UNAVAIL_CAP)) next_rdata = result_q[2];
    if (gso_hit(reg_addr, GSO_ADDR_BLEND_PCT))   next_rdata = result_q[3];
    if (gso_hit(reg_addr, GSO_ADDR_AVAIL_PCT))   next_rdata = result_q[4];
    if (gso_hit(reg_addr, GSO_ADDR_BLEND_CAP))   next_rdata = blended_capacity;
    if (gso_hit(reg_addr, GSO_ADDR_FULL_CAP))    next_rdata = full_capacity_comp;
    if (gso_hit(reg_addr, GSO_ADDR_SHDN_CTRL))   next_rdata = {delay_sel, elapsed_count};
    if (gso_hit(reg_addr, GSO_ADDR_LAST_SAMPLE)) next_rdata = last_charge_sample;
    if (gso_hit(reg_addr, GSO_ADDR_RIPPLE))      next_rdata = result_q[5];
    if (gso_hit(reg_addr, GSO_ADDR_TICK_HIGH))   next_rdata = tick_count_high;
  end

  // Read data is captured on the strobe and held until the next read.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata  <= GSO_WORD_RST;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence low_wrap_seq;
    low_wrap && !tick_high_restore && !wr_tick_hi;
  endsequence
  sequence ctrl_read_seq;
    reg_rd && gso_hit(reg_addr, GSO_ADDR_SHDN_CTRL);
  endsequence

  high_carry_a: assert property (@(posedge clk) disable iff (!rst_b)
    low_wrap_seq |=> tick_count_high == $past(tick_count_high) + 16'h0001
    && tick_count_low == 16'h0000)
    else $error("High word missed the carry from the low word.");
  low_tick_a: assert property (@(posedge clk) disable iff (!rst_b)
    !task_tick |=> tick_count_low == $past(tick_count_low))
    else $error("Low tick counter moved without a tick.");
  dsel_default_a: assert property (@(posedge clk)
    !rst_b |=> delay_sel == 3'h7)
    else $error("Delay select did not reset to seven.");
  ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_read_seq |=> reg_rvalid && reg_rdata[15:13] == $past(delay_sel))
    else $error("Control read lost the delay select.");
  restore_a: assert property (@(posedge clk) disable iff (!rst_b)
    tick_high_restore && tick_high_save_en |=>
    tick_count_high == $past(tick_high_restore_value))
    else $error("High word restore failed.");
  sample_a: assert property (@(posedge clk) disable iff (!rst_b)
    task_tick |=> last_charge_sample == $past(charge_sample))
    else $error("Charge sample was not kept on the tick.");
  blend_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !task_tick |=> $stable(blended_capacity))
    else $error("Blended capacity changed between ticks.");
  result_whole_a: assert property (@(posedge clk) disable iff (!rst_b)
    res_wr && res_sel == GSO_RES_REP_CAP |=> result_q[0] == $past(res_data))
    else $error("Result word did not load whole.");

endmodule

// File: testbench/gso_bank_tb.sv
// Self-checking testbench for the gauge shutdown timer and result register bank.
`timescale 1ns/1ns
module gso_bank_tb
  import gso_pkg::*;
;
  logic clk, rst_b, task_tick, shutdown_pin, reg_wr, reg_rd, reg_rvalid, res_wr;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, res_data, current_sample, charge_sample;
  logic [15:0] full_capacity_nominal, full_cap_temp_factor, design_capacity;
  logic tick_high_save_en, tick_high_restore, regulator_off, low_power;
  logic [15:0] tick_high_restore_value, tick_high_save_value, tick_count_low;
  gso_res_t res_sel;
  int err_total, num_checks, ticks_done;
  // Result words loaded through the engine port, then the readback table.
  logic [15:0] res_val [6] = '{16'h1111, 16'h3280, 16'h0040, 16'h6400, 16'h00ff, 16'hbeef};
  logic [7:0]  row_addr [9] = '{8'h05, 8'h06, 8'h0c, 8'h0d, 8'h0e, 8'hbc, 8'h10, 8'h07, 8'h20};
  logic [15:0] row_exp [9] = '{16'h1111, 16'h3280, 16'h0040, 16'h6400, 16'h00ff, 16'hbeef,
                               16'h1000, 16'h3200, 16'h0000};

  gso_bank i_gso_bank (.clk(clk), .rst_b(rst_b), .task_tick(task_tick),
    .shutdown_pin(shutdown_pin), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .res_wr(res_wr),
    .res_sel(res_sel), .res_data(res_data), .current_sample(current_sample),
    .charge_sample(charge_sample), .full_capacity_nominal(full_capacity_nominal),
    .full_cap_temp_factor(full_cap_temp_factor), .design_capacity(design_capacity),
    .tick_high_save_en(tick_high_save_en), .tick_high_restore(tick_high_restore),
    .tick_high_restore_value(tick_high_restore_value),
    .tick_high_save_value(tick_high_save_value), .tick_count_low(tick_count_low),
    .regulator_off(regulator_off), .low_power(low_power));

  // ----------------------------------------------------------------------
  // Clock, comparison and bus tasks
  // ----------------------------------------------------------------------
  // A 50 ns period gives the 20 MHz system clock.
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // Read strobe lasts one edge; valid data lands one cycle later.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) #2 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk) #2 reg_rd = 1'b0;
    chk("read valid", 16'h0001, {15'h0000, reg_rvalid});
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #2 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #2 reg_wr = 1'b0;
  endtask

  // Holds the task tick for n edges; the bench tracks how many were given.
  task automatic tick(input int n);
    @(posedge clk) #2 task_tick = 1'b1;
    repeat (n - 1) @(posedge clk);
    @(posedge clk) #2 task_tick = 1'b0;
    ticks_done += n;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog sized above the roughly 67k cycles that all tests take together.
  initial begin
    #(50 * 90000);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b, task_tick, shutdown_pin, reg_wr, reg_rd, res_wr, tick_high_restore} = '0;
    {reg_addr, reg_wdata, res_data, charge_sample, tick_high_restore_value} = '0;
    res_sel = GSO_RES_REP_CAP;
    current_sample = 16'h0010;
    full_capacity_nominal = 16'h1000;
    full_cap_temp_factor = 16'h8000;
    design_capacity = 16'h2000;
    tick_high_save_en = 1'b0;
    err_total = 0;
    num_checks = 0;
    ticks_done = 0;
    repeat (12) @(posedge clk);
    #2 rst_b = 1'b1;
    rd(8'h3f, 16'he000);
    rd(8'hbe, 16'h0000);
    $display("test reset done");
    // Whole-word loads, then the readback table including computed words.
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) #2 res_wr = 1'b1;
      res_sel = gso_res_t'(i[2:0]);
      res_data = res_val[i];
      @(posedge clk) #2 res_wr = 1'b0;
    end
    for (int i = 0; i < 9; i++) begin
      rd(row_addr[i], row_exp[i]);
    end
    // A zero design capacity reads as zero age; equal capacities read 100 percent.
    design_capacity = 16'h0000;
    rd(8'h07, 16'h0000);
    design_capacity = 16'h1000;
    rd(8'h07, 16'h6400);
    wr(8'h05, 16'hffff);
    rd(8'h05, 16'h1111);
    $display("test result words done");
    charge_sample = 16'h1234;
    tick(3);
    current_sample = 16'h0000;
    rd(8'h0f, 16'h0030);
    rd(8'h4c, 16'h1234);
    chk("tick low", 16'h0003, tick_count_low);
    wr(8'hbe, 16'h00aa);
    rd(8'hbe, 16'h00aa);
    // A restore while the high word is not enrolled must leave it alone.
    tick_high_restore_value = 16'h5555;
    @(posedge clk) #2 tick_high_restore = 1'b1;
    @(posedge clk) #2 tick_high_restore = 1'b0;
    chk("saved high off", 16'h0000, tick_high_save_value);
    rd(8'hbe, 16'h00aa);
    tick_high_save_en = 1'b1;
    @(posedge clk) #2 tick_high_restore = 1'b1;
    @(posedge clk) #2 tick_high_restore = 1'b0;
    chk("saved high", 16'h5555, tick_high_save_value);
    tick(65536 - ticks_done);
    chk("tick low wrap", 16'h0000, tick_count_low);
    rd(8'hbe, 16'h5556);
    // Negative current steps down and clamps at zero rather than wrapping.
    current_sample = 16'hfff0;
    tick(1);
    rd(8'h0f, 16'h0020);
    current_sample = 16'hff00;
    tick(1);
    rd(8'h0f, 16'h0000);
    current_sample = 16'h0000;
    $display("test tick counter done");
    // Short select, an aborted request, then a full timeout.
    wr(8'h3f, 16'h1fff);
    rd(8'h3f, 16'h0000);
    shutdown_pin = 1'b1;
    repeat (4) @(posedge clk);
    tick(16);
    rd(8'h3f, 16'h0002);
    #2 shutdown_pin = 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h3f, 16'h0000);
    shutdown_pin = 1'b1;
    repeat (4) @(posedge clk);
    tick(255);
    rd(8'h3f, 16'h001f);
    chk("early off", 16'h0000, {15'h0000, regulator_off});
    tick(1);
    repeat (2) @(posedge clk);
    #2;
    chk("regulator off", 16'h0001, {15'h0000, regulator_off});
    chk("low power", 16'h0001, {15'h0000, low_power});
    rd(8'h3f, 16'h0000);
    $display("test shutdown done");
    // Mid-run reset ends the shutdown; select one must double the timeout.
    @(posedge clk) #2 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    chk("off after reset", 16'h0000, {15'h0000, regulator_off});
    rd(8'h3f, 16'he000);
    wr(8'h3f, 16'h2000);
    tick(511);
    rd(8'h3f, 16'h203f);
    chk("late off", 16'h0000, {15'h0000, regulator_off});
    tick(1);
    repeat (2) @(posedge clk);
    #2;
    chk("select one off", 16'h0001, {15'h0000, regulator_off});
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
